// >>> lec_defines.vh
// Offsets, field positions and constants of the link enhancement block
`ifndef LEC_DEFINES_VH
`define LEC_DEFINES_VH
`define LEC_OFS_SET 12'ha88
`define LEC_OFS_CLR 12'ha8c
`define LEC_OFS_CFG 12'hf4
`define LEC_WR_MASK 16'hb582
`define LEC_RESET 16'h1000
`define LEC_BIT_REORDER_DIS 15
`define LEC_THR_HI 13
`define LEC_THR_LO 12
`define LEC_BIT_MPEG 10
`define LEC_BIT_DV 8
`define LEC_BIT_PRIO 7
`define LEC_BIT_ACCEL 1
`define LEC_EE_MASK 16'h0082
`define LEC_THR_SF 2'h0
`define LEC_THR_BYTES_SF 13'h1fff
`define LEC_THR_BYTES_1 13'h06a4
`define LEC_THR_BYTES_2 13'h0400
`define LEC_THR_BYTES_3 13'h0200
`define LEC_FMT_MPEG 6'h20
`define LEC_FMT_DV 6'h00
`define LEC_BYTES_PER_WORD 2
`endif

// >>> lec_top.v
// Link enhancement register and async transmit threshold gate
`timescale 1ns/1ps
`include "lec_defines.vh"

module lec_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire reset_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output reg [AW:0] fill
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire push;
  wire pop;
  // Handshake flags from the fill level
  assign in_ready = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];
  // Storage array, written on push
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // Pointers wrap at the last entry; fill counts words
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        if (wr_ptr == DEPTH[AW-1:0] - 1'b1) begin
          wr_ptr <= {AW{1'b0}};
        end else begin
          wr_ptr <= wr_ptr + 1'b1;
        end
      end
      if (pop) begin
        if (rd_ptr == DEPTH[AW-1:0] - 1'b1) begin
          rd_ptr <= {AW{1'b0}};
        end else begin
          rd_ptr <= rd_ptr + 1'b1;
        end
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end
endmodule

module lec_top #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire reset_n,
  input wire [11:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  output reg reg_rvalid,
  input wire eeprom_load,
  input wire [7:0] eeprom_byte,
  input wire retries_zero,
  input wire retry_active,
  input wire tx_in_valid,
  output wire tx_in_ready,
  input wire [31:0] tx_in_data,
  input wire tx_in_last,
  output wire tx_out_valid,
  input wire tx_out_ready,
  output wire [31:0] tx_out_data,
  output wire tx_out_last,
  output reg tx_underrun,
  output reg store_forward,
  input wire iso_fmt_valid,
  input wire [5:0] iso_fmt,
  output reg mpeg_stamp_apply,
  output reg video_cip_stamp_apply,
  output wire async_tx_reorder_disable,
  output wire mpeg_stamp_enable,
  output wire video_cip_stamp_enable,
  output wire priority_arb_enable,
  output wire accel_notify
);
  // Sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_SEND = 2'b01;
  localparam ST_DROP = 2'b10;

  // Register copy, sticky underrun and transmit state
  reg [15:0] link_enh;
  reg [15:0] next_link_enh;
  reg underrun_seen;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [AW:0] pkt_count;
  reg [12:0] thr_bytes;
  wire [AW:0] fill;
  wire [32:0] fifo_out;
  wire fifo_valid;
  wire fifo_ready;
  wire fifo_pop;
  wire in_push;
  wire [12:0] fill_bytes;
  wire [1:0] thr_field;
  wire sf_mode;
  wire whole_pkt;
  wire start;
  wire sw_write;
  wire underrun_evt;
  wire hit_set;
  wire hit_clr;
  wire hit_cfg;
  wire hit_reg;
  wire mpeg_fmt_hit;
  wire video_fmt_hit;

  // Enhancement bits out to the link
  assign thr_field = link_enh[`LEC_THR_HI:`LEC_THR_LO];
  assign async_tx_reorder_disable = link_enh[`LEC_BIT_REORDER_DIS];
  assign mpeg_stamp_enable = link_enh[`LEC_BIT_MPEG];
  assign video_cip_stamp_enable = link_enh[`LEC_BIT_DV];
  assign priority_arb_enable = link_enh[`LEC_BIT_PRIO];
  assign accel_notify = link_enh[`LEC_BIT_ACCEL];

  // Address decode of the two aliases and the configuration copy
  assign hit_set = (reg_addr == `LEC_OFS_SET);
  assign hit_clr = (reg_addr == `LEC_OFS_CLR);
  assign hit_cfg = (reg_addr == `LEC_OFS_CFG);
  assign hit_reg = hit_set || hit_clr || hit_cfg;

  // Register writes through the aliases and the configuration copy
  assign sw_write = reg_wr && hit_reg;
  always @* begin
    next_link_enh = link_enh;
    if (reg_wr && hit_set) begin
      next_link_enh = link_enh | (reg_wdata[15:0] & `LEC_WR_MASK);
    end else if (reg_wr && hit_clr) begin
      next_link_enh = link_enh & ~(reg_wdata[15:0] & `LEC_WR_MASK);
    end else if (reg_wr && hit_cfg) begin
      next_link_enh = reg_wdata[15:0] & `LEC_WR_MASK;
    end
    if (eeprom_load) begin
      next_link_enh = (next_link_enh & ~`LEC_EE_MASK) |
        ({8'h00, eeprom_byte} & `LEC_EE_MASK);
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_enh <= `LEC_RESET;
    end else begin
      link_enh <= next_link_enh;
    end
  end

  // Read path, one cycle after the strobe
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd && hit_reg) begin
        reg_rdata <= {16'h0000, link_enh & `LEC_WR_MASK};
      end else if (reg_rd) begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // Threshold selection
  always @* begin
    case (thr_field)
      2'b01: begin
        thr_bytes = `LEC_THR_BYTES_1;
      end
      2'b10: begin
        thr_bytes = `LEC_THR_BYTES_2;
      end
      2'b11: begin
        thr_bytes = `LEC_THR_BYTES_3;
      end
      default: begin
        thr_bytes = `LEC_THR_BYTES_SF;
      end
    endcase
  end

  // Store-and-forward whenever any forcing condition holds
  assign sf_mode = (thr_field == `LEC_THR_SF) ||
    underrun_seen ||
    retry_active ||
    retries_zero;

  // Transmit FIFO with end-of-packet flag in the top bit
  assign in_push = tx_in_valid & tx_in_ready;
  assign fifo_pop = fifo_valid & fifo_ready;
  lec_fifo #(
    .WIDTH(33),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(tx_in_valid),
    .in_ready(tx_in_ready),
    .in_data({tx_in_last, tx_in_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_out),
    .fill(fill)
  );

  // Complete packets held in the FIFO
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pkt_count <= {(AW+1){1'b0}};
    end else begin
      if ((in_push && tx_in_last) && !(fifo_pop && fifo_out[32])) begin
        pkt_count <= pkt_count + 1'b1;
      end else if (!(in_push && tx_in_last) && (fifo_pop && fifo_out[32]))
      begin
        pkt_count <= pkt_count - 1'b1;
      end
    end
  end

  // Start condition and underrun detection
  assign fill_bytes = {{(12-AW){1'b0}}, fill} << `LEC_BYTES_PER_WORD;
  assign whole_pkt = (pkt_count != {(AW+1){1'b0}});
  assign start = fifo_valid &&
    (whole_pkt || (!sf_mode && fill_bytes >= thr_bytes));
  assign underrun_evt = (state == ST_SEND) && !fifo_valid;

  // Output stage taken straight from the FIFO head
  assign fifo_ready = ((state == ST_SEND) && tx_out_ready) ||
    (state == ST_DROP);
  assign tx_out_valid = (state == ST_SEND) && fifo_valid;
  assign tx_out_data = fifo_out[31:0];
  assign tx_out_last = fifo_out[32];

  // Transmit sequencer
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!fifo_valid) begin
          next_state = ST_DROP;
        end else if (tx_out_ready && fifo_out[32]) begin
          next_state = ST_IDLE;
        end
      end
      ST_DROP: begin
        if (fifo_valid && fifo_out[32]) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      tx_underrun <= 1'b0;
      store_forward <= 1'b0;
    end else begin
      state <= next_state;
      tx_underrun <= underrun_evt;
      store_forward <= sf_mode;
    end
  end

  // Sticky underrun mode; a new underrun beats a register write
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      underrun_seen <= 1'b0;
    end else if (underrun_evt) begin
      underrun_seen <= 1'b1;
    end else if (sw_write) begin
      underrun_seen <= 1'b0;
    end
  end

  assign mpeg_fmt_hit = iso_fmt_valid && (iso_fmt == `LEC_FMT_MPEG);
  assign video_fmt_hit = iso_fmt_valid && (iso_fmt == `LEC_FMT_DV);

  // Timestamp enhancement marks for isochronous transmit streams
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mpeg_stamp_apply <= 1'b0;
      video_cip_stamp_apply <= 1'b0;
    end else begin
      mpeg_stamp_apply <= mpeg_fmt_hit && mpeg_stamp_enable;
      video_cip_stamp_apply <= video_fmt_hit &&
        video_cip_stamp_enable;
    end
  end
endmodule

// >>> lec_checker.sv
// Concurrent checks on the link enhancement top ports
`timescale 1ns/1ps
module lec_checker (
  input clk,
  input reset_n,
  input [11:0] reg_addr,
  input reg_wr,
  input reg_rd,
  input [31:0] reg_wdata,
  input [31:0] reg_rdata,
  input reg_rvalid,
  input retries_zero,
  input retry_active,
  input tx_underrun,
  input store_forward,
  input iso_fmt_valid,
  input [5:0] iso_fmt,
  input mpeg_stamp_apply,
  input video_cip_stamp_apply,
  input async_tx_reorder_disable,
  input mpeg_stamp_enable,
  input video_cip_stamp_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire set_a = reg_wr && reg_addr == 12'ha88;
  wire clr_a = reg_wr && reg_addr == 12'ha8c;
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no read valid");
  property p_rz; reg_rvalid |-> (reg_rdata & ~32'h0000b582) == 0; endproperty
  a_rz: assert property (p_rz) else $error("reserved bit set");
  property p_set; set_a && reg_wdata[15] |=> async_tx_reorder_disable; endproperty
  a_set: assert property (p_set) else $error("set lost");
  property p_clr; clr_a && reg_wdata[15] |=> !async_tx_reorder_disable; endproperty
  a_clr: assert property (p_clr) else $error("clear lost");
  property p_mp; iso_fmt_valid |=> mpeg_stamp_apply ==
    ($past(iso_fmt) == 6'h20 && $past(mpeg_stamp_enable)); endproperty
  a_mp: assert property (p_mp) else $error("mpeg stamp");
  property p_dv; iso_fmt_valid |=> video_cip_stamp_apply ==
    ($past(iso_fmt) == 6'h00 && $past(video_cip_stamp_enable)); endproperty
  a_dv: assert property (p_dv) else $error("dv stamp");
  property p_sf; (retries_zero || retry_active) [*2] |-> store_forward;
  endproperty
  a_sf: assert property (p_sf) else $error("no store mode");
  property p_ur; tx_underrun |-> ##[0:1] store_forward; endproperty
  a_ur: assert property (p_ur) else $error("underrun mode");
  c_ur: cover property (tx_underrun);
  c_sf: cover property (store_forward);
  c_mp: cover property (mpeg_stamp_apply);
endmodule
bind lec_top lec_checker i_chk (.*);

// >>> lec_link_sink.sv
// Link-side drain model that can stall the transmit stream
`timescale 1ns/1ps
module lec_link_sink (
  input clk,
  input stall,
  input tx_out_valid,
  output tx_out_ready
);
  assign tx_out_ready = !stall;
endmodule

// >>> link_enhancement_control_bench.sv
// Self-checking bench for the link enhancement block
`timescale 1ns/1ps
module link_enhancement_control_bench;
  reg clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, stall = 0;
  reg [11:0] reg_addr = 0;
  reg [31:0] reg_wdata = 0, tx_in_data = 0;
  reg eeprom_load = 0, retries_zero = 0, retry_active = 0, tx_in_valid = 0;
  reg [7:0] eeprom_byte = 0;
  reg tx_in_last = 0, iso_fmt_valid = 0;
  reg [5:0] iso_fmt = 0;
  wire [31:0] reg_rdata, tx_out_data;
  wire reg_rvalid, tx_in_ready, tx_out_valid, tx_out_ready, tx_out_last;
  wire tx_underrun, store_forward, mpeg_stamp_apply, video_cip_stamp_apply;
  wire async_tx_reorder_disable, mpeg_stamp_enable, video_cip_stamp_enable;
  wire priority_arb_enable, accel_notify;
  integer fails = 0, num_checks = 0, i, n;
  reg [31:0] q [$];
  lec_top #(.DEPTH(256), .AW(8)) i_dut (.*);
  lec_link_sink i_sink (.*);
  initial begin
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (tx_out_valid && tx_out_ready)
      q.push_back({tx_out_last, tx_out_data[30:0]});
  task cmp(input [31:0] g, input [31:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("mismatch at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    cmp(reg_rvalid, 1);
    cmp(reg_rdata, e);
  endtask
  task push(input [31:0] d, input l);
    tx_in_data = d;
    tx_in_last = l;
    tx_in_valid = 1;
    @(negedge clk);
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task timeout_hit;
    fails = fails + 1;
    $display("mismatch at %0t wait limit reached", $time);
    report_and_stop;
  endtask
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1;
    rd(12'ha88, 32'h1000);
    wr(12'ha88, 32'hffffffff);
    rd(12'ha8c, 32'hb582);
    cmp({priority_arb_enable, accel_notify}, 2'h3);
    cmp({async_tx_reorder_disable, mpeg_stamp_enable,
      video_cip_stamp_enable}, 3'h7);
    wr(12'ha8c, 32'h8102);
    rd(12'hf4, 32'h3480);
    wr(12'h100, 32'hffffffff);
    rd(12'h100, 32'h0);
    rd(12'ha88, 32'h3480);
    eeprom_byte = 8'h82;
    eeprom_load = 1;
    @(negedge clk);
    eeprom_load = 0;
    wr(12'ha88, 32'h100);
    rd(12'ha88, 32'h3582);
    iso_fmt_valid = 1;
    iso_fmt = 6'h20;
    @(negedge clk);
    cmp(mpeg_stamp_apply, 1);
    iso_fmt = 6'h00;
    @(negedge clk);
    cmp({mpeg_stamp_apply, video_cip_stamp_apply}, 2'h1);
    iso_fmt_valid = 0;
    retries_zero = 1;
    repeat (2) @(negedge clk);
    cmp(store_forward, 1);
    retries_zero = 0;
    retry_active = 1;
    repeat (2) @(negedge clk);
    cmp(store_forward, 1);
    retry_active = 0;
    repeat (2) @(negedge clk);
    cmp(store_forward, 0);
    push(32'ha0, 0);
    tx_in_valid = 0;
    repeat (3) @(negedge clk);
    cmp(tx_out_valid, 0);
    push(32'ha1, 1);
    tx_in_valid = 0;
    for (n = 0; n < 20 && q.size() < 2; n = n + 1) @(negedge clk);
    if (n == 20) timeout_hit;
    cmp({q[0][31], q[0][7:0], q[1][31], q[1][7:0]}, 18'h141a1);
    q.delete();
    stall = 1;
    for (i = 0; i < 300 && tx_in_ready; i = i + 1) push(i, 0);
    tx_in_valid = 0;
    cmp(i, 256);
    cmp(tx_out_valid, 1);
    stall = 0;
    for (n = 0; n < 500 && !tx_underrun; n = n + 1) @(negedge clk);
    if (n == 500) timeout_hit;
    cmp(tx_underrun, 1);
    @(negedge clk);
    cmp(store_forward, 1);
    cmp(q.size(), 256);
    report_and_stop;
  end
endmodule
